// file: bench/two_wire_register_slave_bench.sv
// Self-checking bench: master and slave ends over one two-wire bus.
`timescale 1ns/1ns
`default_nettype none
module two_wire_register_slave_bench;
   import twrs_pkg::*;
   // A short quarter keeps each frame under 2700 cycles.
   localparam int QTR = 8;
   localparam int LIMIT = 6000;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] straps = 3'h0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   twrs_cmd_t cmd_op = TWRS_CMD_WRITE;
   logic [6:0] cmd_dev_addr = 7'h00;
   logic [23:0] cmd_reg_addr = 24'h000000;
   logic [31:0] cmd_wdata = 32'h0000_0000;
   logic [31:0] rsp_rdata;
   logic rsp_valid;
   logic rsp_nack;
   logic [1:0] reg_chan;
   logic [4:0] reg_dev;
   logic [15:0] reg_num;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata = 32'h0000_0000;
   logic reg_valid = 1'b0;
   logic [31:0] reg_mask = 32'h0000_0000;
   logic [31:0] mem [0:15];
   int wr_cnt = 0;
   int drv_cnt = 0;
   int rd_cnt = 0;
   logic [23:0] wr_addr = 24'h000000;
   logic [31:0] wr_data = 32'h0000_0000;
   logic scl_prev = 1'b1;
   logic [35:0] wire_bits = 36'h0;
   int bad_count = 0;
   int n_compared = 0;

   twrs_bus_if bus ();
   always #2 clock = ~clock;

   twrs_master #(.QUARTER(QTR)) i_twrs_master (.clock(clock),
      .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_dev_addr(cmd_dev_addr),
      .cmd_reg_addr(cmd_reg_addr), .cmd_wdata(cmd_wdata),
      .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
      .bus(bus));
   twrs_slave i_twrs_slave (.clock(clock), .resetn(resetn),
      .port_addr_pin_hi(straps[2]), .port_addr_pin_mid(straps[1]),
      .port_addr_pin_lo(straps[0]), .bus(bus), .reg_chan(reg_chan),
      .reg_dev(reg_dev), .reg_num(reg_num), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_valid(reg_valid), .reg_mask(reg_mask));
   twrs_checker i_checker (.clock(clock), .resetn(resetn),
      .scl_i(bus.scl_i), .sda_i(bus.sda_i), .sda_o_s(bus.sda_o_s),
      .sda_oe_n_s(bus.sda_oe_n_s));

   // Register file: channel 1, device 1E; odd numbers hold 16 bits.
   always @(posedge clock) begin
      reg_valid <= (reg_chan == 2'h1) && (reg_dev == 5'h1E);
      reg_mask <= reg_num[0] ? 32'h0000_FFFF : 32'hFFFF_FFFF;
      reg_rdata <= mem[reg_num[3:0]];
      if (reg_wr === 1'b1) begin
         mem[reg_num[3:0]] <= reg_wdata;
         wr_cnt <= wr_cnt + 1;
         wr_addr <= {1'b0, reg_chan, reg_dev, reg_num};
         wr_data <= reg_wdata;
      end
      if (reg_rd === 1'b1) begin
         rd_cnt <= rd_cnt + 1;
      end
      if (bus.sda_oe_n_s === 1'b0) begin
         drv_cnt <= drv_cnt + 1;
      end
      // Bits are taken at each falling clock edge, so a frame's tail
      // lines up at the bottom once the stop has been sent.
      scl_prev <= bus.scl_i;
      if (scl_prev && !bus.scl_i) begin
         wire_bits <= {wire_bits[34:0], bus.sda_i};
      end
   end

   task automatic check(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask

   task automatic close_out();
      if (bad_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic run_cmd(input twrs_cmd_t op, input logic [6:0] da,
         input logic [23:0] ra, input logic [31:0] wd);
      int n;
      n = 0;
      cmd_op <= op;
      cmd_dev_addr <= da;
      cmd_reg_addr <= ra;
      cmd_wdata <= wd;
      cmd_valid <= 1'b1;
      @(posedge clock);
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(posedge clock);
         n++;
      end
      cmd_valid <= 1'b0;
      while (rsp_valid !== 1'b1 && n < LIMIT) begin
         @(posedge clock);
         n++;
      end
      if (n >= LIMIT) begin
         check(1'b0, "command timed out");
         close_out();
      end
   endtask

   function automatic logic [35:0] framed(input logic [31:0] d,
         input logic last);
      return {d[31:24], 1'b0, d[23:16], 1'b0, d[15:8], 1'b0, d[7:0], last};
   endfunction

   // Write then read a full and a half-implemented register.
   task automatic t_write_read(input logic [23:0] base,
         input logic [31:0] d);
      logic [23:0] ra;
      logic [31:0] exp;
      int w0;
      int r0;
      for (int k = 0; k < 2; k++) begin
         ra = base | {23'h0, k[0]};
         exp = k[0] ? (d & 32'h0000_FFFF) : d;
         w0 = wr_cnt;
         run_cmd(TWRS_CMD_WRITE, {TWRS_ADDR_FIXED, straps}, ra, d);
         check(wr_cnt == w0 + 1 && wr_addr === ra, "write address");
         check(wr_data === d, "write data");
         check(wire_bits === framed(d, 1'b0), "write frame");
         r0 = rd_cnt;
         run_cmd(TWRS_CMD_READ, {TWRS_ADDR_FIXED, straps}, ra, 32'h0);
         check(rsp_rdata === exp, "read data");
         check(rd_cnt == r0 + 1, "one fetch per read");
         check(wire_bits === framed(exp, 1'b1), "read frame");
      end
   endtask

   // Bad channel and bad device numbers read as zero.
   task automatic t_invalid();
      logic [23:0] ra;
      for (int k = 0; k < 2; k++) begin
         ra = k[0] ? 24'h3F0100 : 24'h5E0100;
         run_cmd(TWRS_CMD_READ, {TWRS_ADDR_FIXED, straps}, ra, 32'h0);
         check(rsp_rdata === TWRS_ZERO_DATA, "invalid read");
      end
   endtask

   // Only the strapped address is answered; others leave the bus alone.
   task automatic t_straps();
      logic [6:0] da;
      int w0;
      int d0;
      for (int s = 2; s < 8; s += 3) begin
         straps <= s[2:0];
         for (int v = 0; v < 3; v++) begin
            da = (v == 0) ? {TWRS_ADDR_FIXED, s[2:0]} :
               (v == 1) ? {TWRS_ADDR_FIXED, ~s[2:0]} : {4'h4, s[2:0]};
            w0 = wr_cnt;
            d0 = drv_cnt;
            run_cmd(TWRS_CMD_WRITE, da, 24'h3E0102, 32'h1234_5678);
            if (v == 0) begin
               check(wr_cnt == w0 + 1 && drv_cnt > d0 &&
                  rsp_nack === 1'b0, "match");
            end else begin
               check(wr_cnt == w0 && drv_cnt == d0 &&
                  rsp_nack === 1'b1, "no match");
            end
         end
      end
   endtask

   // Recovery sequence leaves the slave quiet and ready again.
   task automatic t_bus_reset();
      int d0;
      d0 = drv_cnt;
      run_cmd(TWRS_CMD_BUS_RESET, 7'h00, 24'h000000, 32'h0);
      check(drv_cnt == d0, "drive in recovery");
      t_write_read(24'h3E0104, 32'h0F1E_2D3C);
   endtask

   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 32'h0000_0000;
      end
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      t_write_read(24'h3E0100, 32'hA5C3_9617);
      t_invalid();
      t_straps();
      t_bus_reset();
      close_out();
   end
endmodule
`default_nettype wire

// file: bench/twrs_checker.sv
// Bus-level checks on the slave's data drive against the shared lines.
`timescale 1ns/1ns
`default_nettype none
module twrs_checker (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Wired bus levels.
   input wire logic scl_i,
   input wire logic sda_i,
   // Slave data drive.
   input wire logic sda_o_s,
   input wire logic sda_oe_n_s
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   sequence start_seen;
      $fell(sda_i) && scl_i && $past(scl_i);
   endsequence
   sequence stop_seen;
      $rose(sda_i) && scl_i && $past(scl_i);
   endsequence

   a_drive_is_low: assert property (!sda_oe_n_s |-> !sda_o_s)
      else $error("slave drives a high level");
   a_drive_on_low: assert property ($fell(sda_oe_n_s) |-> !scl_i)
      else $error("slave took the line while clock high");
   a_release_on_low: assert property ($rose(sda_oe_n_s) |-> !scl_i)
      else $error("slave let go while clock high");
   a_ack_held: assert property ($rose(scl_i) && !sda_oe_n_s |->
      !sda_oe_n_s [*8])
      else $error("slave drive dropped in a high pulse");
   a_no_fake_start: assert property (start_seen |-> $past(sda_oe_n_s))
      else $error("slave made a start edge");
   a_stop_quiet: assert property (stop_seen |-> sda_oe_n_s [*8])
      else $error("slave drove after a stop");
   a_stop_clean: assert property (stop_seen |-> $past(sda_oe_n_s, 2))
      else $error("slave held the line into a stop");
   a_reset_idle: assert property ($rose(resetn) |-> sda_oe_n_s)
      else $error("slave drives out of reset");

   c_start: cover property (start_seen);
   c_stop: cover property (stop_seen);
   c_ack: cover property ($rose(scl_i) && !sda_oe_n_s);
endmodule
`default_nettype wire

// file: hdl/twrs_bus_if.sv
// Two-wire bus carrier joining the register slave and the bus master.
`timescale 1ns/1ns
`default_nettype none
interface twrs_bus_if;
   // Open-drain drives from each end: _o is the level, _oe_n low drives.
   logic scl_o_m;
   logic scl_oe_n_m;
   logic sda_o_m;
   logic sda_oe_n_m;
   logic sda_o_s;
   logic sda_oe_n_s;
   logic scl_i;
   logic sda_i;
   // Wired-AND with pull-up.
   assign scl_i = scl_oe_n_m ? 1'b1 : scl_o_m;
   assign sda_i = (sda_oe_n_m ? 1'b1 : sda_o_m) &
      (sda_oe_n_s ? 1'b1 : sda_o_s);
   modport slave (input scl_i, input sda_i, output sda_o_s,
      output sda_oe_n_s);
   modport master (input scl_i, input sda_i, output scl_o_m,
      output scl_oe_n_m, output sda_o_m, output sda_oe_n_m);
endinterface
`default_nettype wire

// file: hdl/twrs_master.sv
// Bus master end: drives register writes, reads and the recovery sequence.
`timescale 1ns/1ns
`default_nettype none
module twrs_master
   import twrs_pkg::*;
#(
   parameter int QUARTER = TWRS_QUARTER_CYC
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Command side.
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire twrs_cmd_t cmd_op,
   input wire logic [6:0] cmd_dev_addr,
   input wire logic [23:0] cmd_reg_addr,
   input wire logic [31:0] cmd_wdata,
   output logic [31:0] rsp_rdata,
   output logic rsp_valid,
   output logic rsp_nack,
   // Bus side.
   twrs_bus_if.master bus
);
   // Below four cycles the slave's synchroniser cannot keep up.
   if (QUARTER < 4 || QUARTER > 65535) begin : g_bad_quarter
      $error("QUARTER out of range");
   end
   // Each entry of the script is one bit slot of four quarter phases.
   typedef enum logic [1:0] {
      TWRS_M_IDLE = 2'h0,
      TWRS_M_RUN = 2'h1,
      TWRS_M_DONE = 2'h2
   } twrs_mstate_t;

   twrs_mstate_t state_reg;
   logic [15:0] div_reg;
   logic [1:0] ph_reg;
   logic [7:0] slot_reg, last_slot_reg;
   logic [131:0] tx_reg;
   logic [131:0] kind_reg;
   logic [131:0] samp_reg;
   logic [131:0] ack_reg;
   logic [1:0] sync_meta_reg, sync_reg;
   logic scl_reg, sda_reg, nack_reg;
   logic [31:0] rd_reg;

   wire tick = (div_reg == 16'(QUARTER - 1));
   wire sda_now = sync_reg[0];
   wire [7:0] pos = 8'h83 - slot_reg;
   wire is_rd = (cmd_op == TWRS_CMD_READ);
   wire is_rs = (cmd_op == TWRS_CMD_BUS_RESET);
   // Scripts are left-aligned in time order: slot n sits at bit 131 - n.
   wire [131:0] tx_wr = {1'b1, cmd_dev_addr, 1'b0, 1'b1,
      cmd_reg_addr[23:16], 1'b1, cmd_reg_addr[15:8], 1'b1,
      cmd_reg_addr[7:0], 1'b1, cmd_wdata[31:24], 1'b1,
      cmd_wdata[23:16], 1'b1, cmd_wdata[15:8], 1'b1, cmd_wdata[7:0],
      1'b1, 1'b0, 58'h0};
   wire [131:0] tx_rd = {1'b1, cmd_dev_addr, 1'b0, 1'b1,
      cmd_reg_addr[23:16], 1'b1, cmd_reg_addr[15:8], 1'b1,
      cmd_reg_addr[7:0], 1'b1, 1'b1, cmd_dev_addr, 1'b1, 1'b1,
      8'hFF, 1'b0, 8'hFF, 1'b0, 8'hFF, 1'b0, 8'hFF, 1'b1, 1'b0, 48'h0};
   wire [131:0] tx_rs = {11'h7FF, 121'h0};
   // Toggle slots turn a high data line into a start, a low one into a stop.
   wire [131:0] kind_wr = {1'b1, 72'h0, 1'b1, 58'h0};
   wire [131:0] kind_rd = {1'b1, 36'h0, 1'b1, 45'h0, 1'b1, 48'h0};
   wire [131:0] kind_rs = {1'b1, 9'h0, 2'h3, 120'h0};
   wire [131:0] samp_rd = {47'h0, 8'hFF, 1'b0, 8'hFF, 1'b0, 8'hFF, 1'b0,
      8'hFF, 50'h0};
   wire [131:0] ack_wr = {9'h000, {8{1'b1, 8'h00}}, 51'h0};
   wire [131:0] ack_rd = {9'h000, {4{1'b1, 8'h00}}, 1'b0, 1'b1, 85'h0};

   assign cmd_ready = (state_reg == TWRS_M_IDLE);
   assign bus.scl_o_m = 1'b0;
   assign bus.scl_oe_n_m = scl_reg;
   assign bus.sda_o_m = 1'b0;
   assign bus.sda_oe_n_m = sda_reg;
   assign rsp_rdata = rd_reg;
   assign rsp_nack = nack_reg;
   assign rsp_valid = (state_reg == TWRS_M_DONE);

   always_ff @(posedge clock) begin
      if (!resetn) begin
         sync_meta_reg <= 2'h3;
         sync_reg <= 2'h3;
      end else begin
         sync_meta_reg <= {bus.scl_i, bus.sda_i};
         sync_reg <= sync_meta_reg;
      end
   end

   // Each slot drives its data level, may toggle it while the clock is
   // high, and may sample read data or a slave acknowledge.
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_reg <= TWRS_M_IDLE;
         div_reg <= 16'h0000;
         ph_reg <= 2'h0;
         slot_reg <= 8'h00;
         last_slot_reg <= 8'h00;
         tx_reg <= '0;
         kind_reg <= '0;
         samp_reg <= '0;
         ack_reg <= '0;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         nack_reg <= 1'b0;
         rd_reg <= 32'h0000_0000;
      end else begin
         case (state_reg)
            TWRS_M_IDLE: begin
               if (cmd_valid) begin
                  state_reg <= TWRS_M_RUN;
                  nack_reg <= 1'b0;
                  div_reg <= 16'h0000;
                  ph_reg <= 2'h0;
                  slot_reg <= 8'h00;
                  tx_reg <= is_rs ? tx_rs : is_rd ? tx_rd : tx_wr;
                  kind_reg <= is_rs ? kind_rs : is_rd ? kind_rd : kind_wr;
                  samp_reg <= is_rd ? samp_rd : '0;
                  ack_reg <= is_rs ? '0 : is_rd ? ack_rd : ack_wr;
                  last_slot_reg <= is_rs ? 8'h0B : is_rd ? 8'h53 : 8'h49;
               end
            end
            TWRS_M_RUN: begin
               div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
               if (tick) begin
                  ph_reg <= ph_reg + 2'h1;
                  case (ph_reg)
                     2'h0: sda_reg <= tx_reg[pos];
                     2'h1: scl_reg <= 1'b1;
                     2'h2: begin
                        if (kind_reg[pos])
                           sda_reg <= ~sda_reg;
                        if (samp_reg[pos])
                           rd_reg <= {rd_reg[30:0], sda_now};
                        if (ack_reg[pos] && sda_now)
                           nack_reg <= 1'b1;
                     end
                     default: begin
                        scl_reg <= 1'b0;
                        slot_reg <= slot_reg + 8'h01;
                        if (slot_reg == last_slot_reg) begin
                           state_reg <= TWRS_M_DONE;
                           scl_reg <= 1'b1;
                           sda_reg <= 1'b1;
                        end
                     end
                  endcase
               end
            end
            TWRS_M_DONE: state_reg <= TWRS_M_IDLE;
            default: state_reg <= TWRS_M_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: hdl/twrs_pkg.sv
// Shared constants and types for the two-wire register slave and its master.
package twrs_pkg;
   localparam logic [3:0] TWRS_ADDR_FIXED = 4'h8;
   localparam int TWRS_ADDR_BYTES = 3;
   localparam int TWRS_DATA_BYTES = 4;
   localparam int TWRS_SYS_PERIOD_NS = 4;
   // Bus bit period at the highest permitted rate, in ns.
   localparam int TWRS_BIT_PERIOD_NS = 2500;
   // Master clock divider: quarter bit period, rounded up so the rate stays
   // at or below the limit.
   localparam int TWRS_QUARTER_CYC =
      (TWRS_BIT_PERIOD_NS / 4 + TWRS_SYS_PERIOD_NS - 1) / TWRS_SYS_PERIOD_NS;
   localparam int TWRS_RESET_PULSES = 9;
   localparam logic [31:0] TWRS_ZERO_DATA = 32'h0000_0000;
   typedef enum logic [1:0] {
      TWRS_CMD_WRITE = 2'h0,
      TWRS_CMD_READ = 2'h1,
      TWRS_CMD_BUS_RESET = 2'h2
   } twrs_cmd_t;
endpackage

// file: hdl/twrs_slave.sv
`timescale 1ns/1ns
`default_nettype none
module twrs_slave
   import twrs_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Address straps.
   input wire logic port_addr_pin_hi,
   input wire logic port_addr_pin_mid,
   input wire logic port_addr_pin_lo,
   // Bus side.
   twrs_bus_if.slave bus,
   // Register access side.
   output logic [1:0] reg_chan,
   output logic [4:0] reg_dev,
   output logic [15:0] reg_num,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_valid,
   input wire logic [31:0] reg_mask
);
   typedef enum logic [2:0] {
      TWRS_IDLE = 3'h0,
      TWRS_RECV = 3'h1,
      TWRS_ACK = 3'h2,
      TWRS_SEND = 3'h3,
      TWRS_MACK = 3'h4
   } twrs_state_t;

   twrs_state_t state_reg, state_next;
   logic scl, sda, scl_rise, scl_fall, start_det, stop_det;
   logic [2:0] pins_meta_reg, pins_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_reg;
   logic [2:0] byte_reg;
   logic first_reg, rnw_reg, drive_low_reg;
   logic wr_pulse_reg;
   logic [23:0] addr_reg;
   logic [31:0] data_reg;

   twrs_sync u_sync (
      .clock(clock),
      .resetn(resetn),
      .scl_in(bus.scl_i),
      .sda_in(bus.sda_i),
      .scl(scl),
      .sda(sda),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det)
   );

   wire [6:0] my_addr = {TWRS_ADDR_FIXED, pins_reg};
   wire [7:0] rx_byte = {shift_reg[6:0], sda};
   wire addr_hit = (rx_byte[7:1] == my_addr);
   wire byte_done = scl_rise && (bit_reg == 4'h7);
   wire [31:0] fetched = reg_valid ? (reg_rdata & reg_mask) : TWRS_ZERO_DATA;
   wire word_end = (byte_reg == 3'(TWRS_ADDR_BYTES + TWRS_DATA_BYTES - 1));
   // The write strobe trails the last byte by one cycle, so the word has
   // landed in data_reg before the register side sees the strobe.
   wire wr_hit = (state_reg == TWRS_RECV) && byte_done && !first_reg &&
      (byte_reg == 3'(TWRS_ADDR_BYTES + TWRS_DATA_BYTES - 1));

   assign reg_chan = addr_reg[22:21];
   assign reg_dev = addr_reg[20:16];
   assign reg_num = addr_reg[15:0];
   assign reg_wdata = data_reg;
   assign reg_wr = wr_pulse_reg;
   assign reg_rd = ((state_reg == TWRS_ACK) && scl_fall && rnw_reg &&
      drive_low_reg && first_reg) ||
      ((state_reg == TWRS_MACK) && scl_fall && byte_reg == 3'h0);
   assign bus.sda_o_s = 1'b0;
   assign bus.sda_oe_n_s = !drive_low_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         TWRS_IDLE: state_next = TWRS_IDLE;
         TWRS_RECV: begin
            if (byte_done) begin
               if (first_reg && !addr_hit)
                  state_next = TWRS_IDLE;
               else
                  state_next = TWRS_ACK;
            end
         end
         TWRS_ACK: begin
            if (scl_fall && drive_low_reg)
               state_next = rnw_reg ? TWRS_SEND : TWRS_RECV;
         end
         TWRS_SEND: begin
            if (scl_fall && bit_reg == 4'h8)
               state_next = TWRS_MACK;
         end
         TWRS_MACK: begin
            if (scl_rise && sda)
               state_next = TWRS_IDLE;
            else if (scl_fall)
               state_next = TWRS_SEND;
         end
         default: state_next = TWRS_IDLE;
      endcase
      if (start_det)
         state_next = TWRS_RECV;
      else if (stop_det)
         state_next = TWRS_IDLE;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         pins_meta_reg <= 3'h0;
         pins_reg <= 3'h0;
      end else begin
         pins_meta_reg <= {port_addr_pin_hi, port_addr_pin_mid,
            port_addr_pin_lo};
         pins_reg <= pins_meta_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_reg <= TWRS_IDLE;
         shift_reg <= 8'h00;
         bit_reg <= 4'h0;
         byte_reg <= 3'h0;
         first_reg <= 1'b0;
         rnw_reg <= 1'b0;
         drive_low_reg <= 1'b0;
         addr_reg <= 24'h00_0000;
         data_reg <= 32'h0000_0000;
         wr_pulse_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         wr_pulse_reg <= wr_hit;
         if (start_det) begin
            bit_reg <= 4'h0;
            first_reg <= 1'b1;
            drive_low_reg <= 1'b0;
         end else if (stop_det || state_next == TWRS_IDLE) begin
            drive_low_reg <= 1'b0;
         end else begin
            case (state_reg)
               TWRS_RECV: begin
                  if (scl_rise) begin
                     shift_reg <= rx_byte;
                     bit_reg <= bit_reg + 4'h1;
                  end
                  if (byte_done && first_reg) begin
                     rnw_reg <= rx_byte[0];
                     if (!rx_byte[0])
                        byte_reg <= 3'h0;
                  end else if (byte_done) begin
                     if (byte_reg < 3'(TWRS_ADDR_BYTES))
                        addr_reg <= {addr_reg[15:0], rx_byte};
                     else
                        data_reg <= {data_reg[23:0], rx_byte};
                  end
               end
               TWRS_ACK: begin
                  if (scl_fall && !drive_low_reg) begin
                     drive_low_reg <= 1'b1;
                  end else if (scl_fall) begin
                     first_reg <= 1'b0;
                     bit_reg <= 4'h0;
                     if (!first_reg)
                        byte_reg <= word_end ? 3'(TWRS_ADDR_BYTES)
                           : byte_reg + 3'h1;
                     if (rnw_reg) begin
                        data_reg <= (first_reg || byte_reg == 3'h0) ?
                           fetched : data_reg;
                        drive_low_reg <= ~((first_reg || byte_reg == 3'h0) ?
                           fetched[31] : data_reg[31]);
                        byte_reg <= 3'h0;
                        bit_reg <= 4'h1;
                     end else begin
                        drive_low_reg <= 1'b0;
                     end
                  end
               end
               TWRS_SEND: begin
                  if (scl_fall && bit_reg != 4'h8) begin
                     data_reg <= {data_reg[30:0], 1'b0};
                     drive_low_reg <= ~data_reg[30];
                     bit_reg <= bit_reg + 4'h1;
                  end else if (scl_fall) begin
                     drive_low_reg <= 1'b0;
                     data_reg <= {data_reg[30:0], 1'b0};
                  end
               end
               TWRS_MACK: begin
                  if (scl_rise) begin
                     bit_reg <= 4'h1;
                     byte_reg <= byte_reg + 3'h1;
                     if (byte_reg == 3'(TWRS_DATA_BYTES - 1)) begin
                        byte_reg <= 3'h0;
                        addr_reg[15:0] <= addr_reg[15:0] + 16'h0001;
                     end
                  end
                  if (scl_fall) begin
                     data_reg <= (byte_reg == 3'h0) ? fetched : data_reg;
                     drive_low_reg <= ~((byte_reg == 3'h0) ?
                        fetched[31] : data_reg[31]);
                  end
               end
               default: drive_low_reg <= 1'b0;
            endcase
            if (wr_pulse_reg)
               addr_reg[15:0] <= addr_reg[15:0] + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/twrs_sync.sv
// Two-flop synchroniser with edge and condition detection on the bus pins.
`timescale 1ns/1ns
`default_nettype none
module twrs_sync (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Raw bus levels.
   input wire logic scl_in,
   input wire logic sda_in,
   // Clean levels and events.
   output logic scl,
   output logic sda,
   output logic scl_rise,
   output logic scl_fall,
   output logic start_det,
   output logic stop_det
);
   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [1:0] last_reg;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         meta_reg <= 2'h3;
         sync_reg <= 2'h3;
         last_reg <= 2'h3;
      end else begin
         meta_reg <= {scl_in, sda_in};
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end
   assign scl = sync_reg[1];
   assign sda = sync_reg[0];
   assign scl_rise = sync_reg[1] & ~last_reg[1];
   assign scl_fall = ~sync_reg[1] & last_reg[1];
   assign start_det = sync_reg[1] & last_reg[1] & last_reg[0] & ~sync_reg[0];
   assign stop_det = sync_reg[1] & last_reg[1] & ~last_reg[0] & sync_reg[0];
endmodule
`default_nettype wire
